//--- hdl/switch_port_link_control_map.vh
// register map, field positions, reset values and timing figures of the port link control
`ifndef SWITCH_PORT_LINK_CONTROL_MAP_VH
`define SWITCH_PORT_LINK_CONTROL_MAP_VH

// register byte addresses
`define REG_CTRL 8'h00
`define REG_RANGE 8'h04
`define REG_STATUS 8'h08

// control register fields
`define CTRL_ADMIN 0
`define CTRL_SPEED_LO 1
`define CTRL_SPEED_HI 3
`define CTRL_FLOW 4
`define CTRL_LOOP 5

// range command fields
`define RANGE_FIRST_LO 0
`define RANGE_FIRST_HI 3
`define RANGE_LAST_LO 4
`define RANGE_LAST_HI 7
`define RANGE_SHUT 8

// status register fields
`define STAT_LINK 0
`define STAT_SPEED_LO 1
`define STAT_SPEED_HI 2
`define STAT_FULL 3
`define STAT_XOVER 4
`define STAT_NEGOTIATED 5
`define STAT_PAUSE 6
`define STAT_JAM 7
`define STAT_ADMIN 8

// speed and duplex selection codes
`define SEL_AUTO 3'h0
`define SEL_10F 3'h1
`define SEL_10H 3'h2
`define SEL_100F 3'h3
`define SEL_100H 3'h4
`define SEL_1000F 3'h5
`define SEL_LAST 3'h5

// resolved speed codes
`define SPD_10 2'h0
`define SPD_100 2'h1
`define SPD_1000 2'h2

// ability bit positions: 10 half, 10 full, 100 half, 100 full, 1000 full
`define AB_10H 0
`define AB_10F 1
`define AB_100H 2
`define AB_100F 3
`define AB_1000F 4
`define AB_ALL 5'h1f
`define AB_NONE 5'h00

// reset values
`define RST_ADMIN 1'h1
`define RST_FLOW 1'h0
`define RST_LOOP 1'h0

// timing
`define CLK_PERIOD_NS 10
`define AN_WAIT_US 1000
`define AN_TIMER_W 17

`endif

//--- hdl/switch_port_link_control.v
// per-port link control: admin state, speed and duplex, crossover, flow control, loopback
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`include "switch_port_link_control_map.vh"
//
// Operation
// - auto mode negotiates common best speed and duplex
// - silent partner: detected speed, half duplex
// - forced mode links only at configured setting
// - gigabit reached only through auto-negotiation
// - accept only auto, 10F, 10H, 100F, 100H, 1000F
// - reset gives auto selection, flow control off
// - full duplex congestion sends pause request
// - half duplex congestion drives jam collision
// - half duplex never starts sending while receiving
// - crossover follows cable only in auto
// - MAC loopback returns transmit data as receive
// - admin enable, shutdown for single port or range
module switch_port_link_control #(
   parameter [3:0] PORT_NUM = 4'h1,
   parameter [`AN_TIMER_W-1:0] AN_WAIT_CYCLES = (`AN_WAIT_US * 1000) / `CLK_PERIOD_NS
) (
   // clock, reset, enable
   input wire clk,
   input wire reset,
   input wire ce,
   // register port
   input wire [7:0] regAddr,
   input wire [31:0] regWrData,
   input wire regWr,
   input wire regRd,
   output reg [31:0] regRdData_q,
   // negotiation and line detection from the physical layer
   input wire partnerPageValid,
   input wire [4:0] partnerAbility,
   input wire lineSignalValid,
   input wire [1:0] lineSpeedDetect,
   input wire cableCrossed,
   output reg anEnable_q,
   output reg [4:0] advertise_q,
   output reg crossover_q,
   // resolved link state
   output reg linkUp_q,
   output reg [1:0] speed_q,
   output reg fullDuplex_q,
   // frames from the switch core toward the line
   input wire txValid,
   input wire [7:0] txData,
   output reg txReady_q,
   output reg lineTxEn_q,
   output reg [7:0] lineTxData_q,
   // frames from the line toward the switch core
   input wire lineRxDv,
   input wire [7:0] lineRxData,
   output reg rxValid_q,
   output reg [7:0] rxData_q,
   // flow control
   input wire rxCongested,
   output reg pauseReq_q,
   output reg lineJam_q
);

   localparam [1:0] ST_DOWN = 2'h0;
   localparam [1:0] ST_NEG = 2'h1;
   localparam [1:0] ST_UP = 2'h2;

   // abilities offered for a selection code; gigabit only ever as an advertisement
   function [4:0] selAbility;
      input [2:0] sel;
      begin
         case (sel)
            `SEL_10F: selAbility = 5'h1 << `AB_10F;
            `SEL_10H: selAbility = 5'h1 << `AB_10H;
            `SEL_100F: selAbility = 5'h1 << `AB_100F;
            `SEL_100H: selAbility = 5'h1 << `AB_100H;
            `SEL_1000F: selAbility = 5'h1 << `AB_1000F;
            default: selAbility = `AB_ALL;
         endcase
      end
   endfunction

   // speed code of a single ability bit set
   function [1:0] abilitySpeed;
      input [4:0] ab;
      begin
         if (ab[`AB_1000F])
            abilitySpeed = `SPD_1000;
         else if (ab[`AB_100F] || ab[`AB_100H])
            abilitySpeed = `SPD_100;
         else
            abilitySpeed = `SPD_10;
      end
   endfunction

   // highest common ability, gigabit first
   function [4:0] bestCommon;
      input [4:0] ab;
      begin
         if (ab[`AB_1000F])
            bestCommon = 5'h1 << `AB_1000F;
         else if (ab[`AB_100F])
            bestCommon = 5'h1 << `AB_100F;
         else if (ab[`AB_100H])
            bestCommon = 5'h1 << `AB_100H;
         else if (ab[`AB_10F])
            bestCommon = 5'h1 << `AB_10F;
         else if (ab[`AB_10H])
            bestCommon = 5'h1 << `AB_10H;
         else
            bestCommon = `AB_NONE;
      end
   endfunction

   reg adminEn_q;
   reg [2:0] speedSel_q;
   reg flowCtrl_q;
   reg loopback_q;
   reg [1:0] state_q;
   reg [`AN_TIMER_W-1:0] anTimer_q;
   reg negotiated_q;
   reg cfgChanged_q;

   wire ctrlWrite = regWr && (regAddr == `REG_CTRL);
   wire rangeWrite = regWr && (regAddr == `REG_RANGE);
   wire [2:0] wrSel = regWrData[`CTRL_SPEED_HI:`CTRL_SPEED_LO];
   wire [3:0] rangeFirst = regWrData[`RANGE_FIRST_HI:`RANGE_FIRST_LO];
   wire [3:0] rangeLast = regWrData[`RANGE_LAST_HI:`RANGE_LAST_LO];
   wire inRange = (PORT_NUM >= rangeFirst) && (PORT_NUM <= rangeLast);
   wire autoSel = (speedSel_q == `SEL_AUTO);
   wire forcedMode = (speedSel_q != `SEL_AUTO) && (speedSel_q != `SEL_1000F);
   wire [4:0] forcedAb = selAbility(speedSel_q);
   wire [4:0] common = bestCommon(advertise_q & partnerAbility);
   wire halfBusy = !fullDuplex_q && lineRxDv && !lineTxEn_q;
   wire congestedFlow = flowCtrl_q && rxCongested && linkUp_q && adminEn_q && !loopback_q;
   wire txTake = txValid && txReady_q;

   // configuration registers; illegal selection codes leave the old setting in place
   always @(posedge clk)
   begin
      if (reset)
      begin
         adminEn_q <= `RST_ADMIN;
         speedSel_q <= `SEL_AUTO;
         flowCtrl_q <= `RST_FLOW;
         loopback_q <= `RST_LOOP;
         cfgChanged_q <= 1'b0;
      end
      else if (ce)
      begin
         cfgChanged_q <= ctrlWrite || (rangeWrite && inRange);
         if (ctrlWrite)
         begin
            adminEn_q <= regWrData[`CTRL_ADMIN];
            if (wrSel <= `SEL_LAST)
               speedSel_q <= wrSel;
            flowCtrl_q <= regWrData[`CTRL_FLOW];
            loopback_q <= regWrData[`CTRL_LOOP];
         end
         else if (rangeWrite && inRange)
            adminEn_q <= !regWrData[`RANGE_SHUT];
      end
   end

   // read data stands only in the cycle after the strobe; unmapped reads give zero
   always @(posedge clk)
   begin
      if (reset)
         regRdData_q <= 32'h0;
      else if (ce)
      begin
         regRdData_q <= 32'h0;
         if (regRd)
         begin
            if (regAddr == `REG_CTRL)
            begin
               regRdData_q[`CTRL_ADMIN] <= adminEn_q;
               regRdData_q[`CTRL_SPEED_HI:`CTRL_SPEED_LO] <= speedSel_q;
               regRdData_q[`CTRL_FLOW] <= flowCtrl_q;
               regRdData_q[`CTRL_LOOP] <= loopback_q;
            end
            else if (regAddr == `REG_STATUS)
            begin
               regRdData_q[`STAT_LINK] <= linkUp_q;
               regRdData_q[`STAT_SPEED_HI:`STAT_SPEED_LO] <= speed_q;
               regRdData_q[`STAT_FULL] <= fullDuplex_q;
               regRdData_q[`STAT_XOVER] <= crossover_q;
               regRdData_q[`STAT_NEGOTIATED] <= negotiated_q;
               regRdData_q[`STAT_PAUSE] <= pauseReq_q;
               regRdData_q[`STAT_JAM] <= lineJam_q;
               regRdData_q[`STAT_ADMIN] <= adminEn_q;
            end
         end
      end
   end

   // link state machine; any configuration change restarts the link from down
   always @(posedge clk)
   begin
      if (reset)
      begin
         state_q <= ST_DOWN;
         anTimer_q <= {`AN_TIMER_W{1'b0}};
         anEnable_q <= 1'b1;
         advertise_q <= `AB_ALL;
         linkUp_q <= 1'b0;
         speed_q <= `SPD_10;
         fullDuplex_q <= 1'b0;
         negotiated_q <= 1'b0;
      end
      else if (ce)
      begin
         anEnable_q <= !forcedMode;
         advertise_q <= forcedMode ? `AB_NONE : forcedAb;
         if (!adminEn_q || cfgChanged_q || !lineSignalValid)
         begin
            state_q <= ST_DOWN;
            linkUp_q <= 1'b0;
            negotiated_q <= 1'b0;
            anTimer_q <= {`AN_TIMER_W{1'b0}};
         end
         else
         begin
            case (state_q)
               ST_DOWN:
               begin
                  anTimer_q <= {`AN_TIMER_W{1'b0}};
                  if (forcedMode)
                  begin
                     // the partner must be set to the same speed; duplex is taken as configured
                     if (lineSpeedDetect == abilitySpeed(forcedAb))
                     begin
                        state_q <= ST_UP;
                        linkUp_q <= 1'b1;
                        speed_q <= abilitySpeed(forcedAb);
                        fullDuplex_q <= forcedAb[`AB_10F] || forcedAb[`AB_100F];
                     end
                  end
                  else
                     state_q <= ST_NEG;
               end
               ST_NEG:
               begin
                  if (partnerPageValid)
                  begin
                     // no common ability keeps the port negotiating
                     if (common != `AB_NONE)
                     begin
                        state_q <= ST_UP;
                        linkUp_q <= 1'b1;
                        negotiated_q <= 1'b1;
                        speed_q <= abilitySpeed(common);
                        fullDuplex_q <= common[`AB_1000F] || common[`AB_100F] || common[`AB_10F];
                     end
                  end
                  else if (anTimer_q >= AN_WAIT_CYCLES)
                  begin
                     // parallel detection cannot reach gigabit and only 10 or 100 half qualify
                     if (autoSel && (lineSpeedDetect != `SPD_1000))
                     begin
                        state_q <= ST_UP;
                        linkUp_q <= 1'b1;
                        speed_q <= lineSpeedDetect;
                        fullDuplex_q <= 1'b0;
                     end
                     else
                        anTimer_q <= {`AN_TIMER_W{1'b0}};
                  end
                  else
                     anTimer_q <= anTimer_q + 1'b1;
               end
               ST_UP:
                  linkUp_q <= 1'b1;
               default:
               begin
                  state_q <= ST_DOWN;
                  linkUp_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // crossover only follows the cable when the selection is auto; otherwise fixed straight
   always @(posedge clk)
   begin
      if (reset)
         crossover_q <= 1'b0;
      else if (ce)
         crossover_q <= autoSel ? cableCrossed : 1'b0;
   end

   // flow control: pause in full duplex, collision jam in half duplex
   always @(posedge clk)
   begin
      if (reset)
      begin
         pauseReq_q <= 1'b0;
         lineJam_q <= 1'b0;
      end
      else if (ce)
      begin
         pauseReq_q <= congestedFlow && fullDuplex_q;
         // jam only while the sender is on the wire, so that it sees a collision
         lineJam_q <= congestedFlow && !fullDuplex_q && lineRxDv;
      end
   end

   // transmit path; the ready term lags carrier by one cycle, so the send gate rechecks it
   always @(posedge clk)
   begin
      if (reset)
      begin
         txReady_q <= 1'b0;
         lineTxEn_q <= 1'b0;
         lineTxData_q <= 8'h0;
      end
      else if (ce)
      begin
         txReady_q <= adminEn_q && (loopback_q || (linkUp_q && !halfBusy && !lineJam_q));
         lineTxEn_q <= txTake && !loopback_q && linkUp_q && !halfBusy;
         lineTxData_q <= (txTake && !loopback_q) ? txData : 8'h0;
      end
   end

   // receive path: line data, or in loopback the accepted transmit data
   always @(posedge clk)
   begin
      if (reset)
      begin
         rxValid_q <= 1'b0;
         rxData_q <= 8'h0;
      end
      else if (ce)
      begin
         if (!adminEn_q)
         begin
            rxValid_q <= 1'b0;
            rxData_q <= 8'h0;
         end
         else if (loopback_q)
         begin
            rxValid_q <= txTake;
            rxData_q <= txData;
         end
         else
         begin
            rxValid_q <= lineRxDv && linkUp_q;
            rxData_q <= lineRxDv ? lineRxData : 8'h0;
         end
      end
   end

endmodule

//--- dv/switch_port_link_control_props.sv
// assertion checker for the port link control, bound to its ports
`timescale 1ns/100ps
`include "switch_port_link_control_map.vh"
module switch_port_link_control_chk (
   // clock and reset
   input wire clk,
   input wire reset,
   // line side and core side inputs
   input wire partnerPageValid,
   input wire lineSignalValid,
   input wire lineRxDv,
   input wire rxCongested,
   input wire txValid,
   input wire [7:0] txData,
   // link and data outputs
   input wire anEnable_q,
   input wire crossover_q,
   input wire linkUp_q,
   input wire [1:0] speed_q,
   input wire fullDuplex_q,
   input wire txReady_q,
   input wire lineTxEn_q,
   input wire [7:0] lineTxData_q,
   input wire pauseReq_q,
   input wire lineJam_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // receiving in half duplex with nothing in flight
   sequence s_rx_half;
      linkUp_q && !fullDuplex_q && lineRxDv && !lineTxEn_q && !(txValid && txReady_q);
   endsequence
   sequence s_no_signal;
      !lineSignalValid;
   endsequence
   property p_xover;
      !anEnable_q [*2] |-> !crossover_q;
   endproperty
   a_xover: assert property (p_xover) else $error("crossover outside auto");
   property p_forced;
      linkUp_q && !anEnable_q |-> speed_q != `SPD_1000;
   endproperty
   a_forced: assert property (p_forced) else $error("forced gigabit link");
   property p_gig;
      linkUp_q && speed_q == `SPD_1000 |-> fullDuplex_q && anEnable_q;
   endproperty
   a_gig: assert property (p_gig) else $error("gigabit without negotiation");
   // a full duplex auto link must come from a page, never from detection
   property p_fdx;
      $rose(linkUp_q) && anEnable_q && fullDuplex_q |-> $past(partnerPageValid);
   endproperty
   a_fdx: assert property (p_fdx) else $error("full duplex without page");
   property p_half;
      s_rx_half |=> !txReady_q;
   endproperty
   a_half: assert property (p_half) else $error("ready while receiving");
   property p_pause;
      pauseReq_q |-> $past(rxCongested && linkUp_q && fullDuplex_q) && !lineJam_q;
   endproperty
   a_pause: assert property (p_pause) else $error("pause without cause");
   property p_jam;
      lineJam_q |-> $past(rxCongested && linkUp_q && !fullDuplex_q && lineRxDv);
   endproperty
   a_jam: assert property (p_jam) else $error("jam without cause");
   property p_tx;
      lineTxEn_q |-> $past(txValid && txReady_q && linkUp_q) && lineTxData_q == $past(txData);
   endproperty
   a_tx: assert property (p_tx) else $error("line byte not taken");
   property p_drop;
      s_no_signal |=> !linkUp_q;
   endproperty
   a_drop: assert property (p_drop) else $error("link up without signal");
endmodule
bind switch_port_link_control switch_port_link_control_chk chk (.*);

//--- dv/link_peer_model.sv
// behavioural peer port at the far end of the cable
`timescale 1ns/100ps
module link_peer_model (
   // clock and peer setup
   input wire clk,
   input wire peerOn,
   input wire peerAneg,
   input wire [4:0] peerAbility,
   input wire [1:0] peerSpeed,
   input wire peerCrossed,
   input wire sendReq,
   // what our port shows the cable
   input wire anEnable_q,
   input wire pauseReq_q,
   input wire lineJam_q,
   // what the peer puts on the cable
   output reg partnerPageValid = 1'b0,
   output reg [4:0] partnerAbility = 5'h00,
   output reg lineSignalValid = 1'b0,
   output reg [1:0] lineSpeedDetect = 2'h0,
   output reg cableCrossed = 1'b0,
   output reg lineRxDv = 1'b0,
   output reg [7:0] lineRxData = 8'h00
);
   // cable starts quiet; each output has its single driver in the clocked processes below
   reg [7:0] seq_q = 8'h00;
   // pages flow only while both ends negotiate; a forced peer must match our setting
   always @(posedge clk)
   begin
      partnerPageValid <= peerOn && peerAneg && anEnable_q;
      partnerAbility <= peerAneg ? peerAbility : ~peerAbility;
      lineSignalValid <= peerOn;
      lineSpeedDetect <= peerSpeed;
      cableCrossed <= peerCrossed;
   end
   // sender backs off on pause or collision; idle data is junk so it is never trusted
   always @(posedge clk)
   begin
      lineRxDv <= sendReq && peerOn && !lineJam_q && !pauseReq_q;
      seq_q <= seq_q + 8'h01;
      lineRxData <= (sendReq && peerOn && !lineJam_q && !pauseReq_q) ? seq_q : ~lineRxData;
   end
endmodule

//--- dv/tb.sv
// self-checking bench for the port link control
`timescale 1ns/100ps
`include "switch_port_link_control_map.vh"
module tb;
   reg clk = 1'b0;
   reg reset = 1'b1;
   reg ce = 1'b1;
   reg [7:0] regAddr = 8'h00;
   reg [31:0] regWrData = 32'h0;
   reg regWr = 1'b0;
   reg regRd = 1'b0;
   reg txValid = 1'b0;
   reg [7:0] txData = 8'h00;
   reg rxCongested = 1'b0;
   reg peerOn = 1'b0;
   reg peerAneg = 1'b1;
   reg [4:0] peerAbility = 5'h0c;
   reg [1:0] peerSpeed = `SPD_100;
   reg peerCrossed = 1'b1;
   reg sendReq = 1'b0;
   reg seen;
   reg [7:0] i;
   integer n_mismatch = 0;
   integer checked = 0;
   wire [31:0] regRdData_q;
   wire [4:0] partnerAbility, advertise_q;
   wire [1:0] lineSpeedDetect, speed_q;
   wire [7:0] lineTxData_q, lineRxData, rxData_q;
   wire partnerPageValid, lineSignalValid, cableCrossed, anEnable_q, crossover_q, linkUp_q;
   wire fullDuplex_q, txReady_q, lineTxEn_q, lineRxDv, rxValid_q, pauseReq_q, lineJam_q;
   switch_port_link_control #(.AN_WAIT_CYCLES(17'h14)) dut (
      .clk(clk), .reset(reset), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData_q(regRdData_q), .partnerPageValid(partnerPageValid),
      .partnerAbility(partnerAbility), .lineSignalValid(lineSignalValid),
      .lineSpeedDetect(lineSpeedDetect), .cableCrossed(cableCrossed), .anEnable_q(anEnable_q),
      .advertise_q(advertise_q), .crossover_q(crossover_q), .linkUp_q(linkUp_q), .speed_q(speed_q),
      .fullDuplex_q(fullDuplex_q), .txValid(txValid), .txData(txData), .txReady_q(txReady_q),
      .lineTxEn_q(lineTxEn_q), .lineTxData_q(lineTxData_q), .lineRxDv(lineRxDv),
      .lineRxData(lineRxData), .rxValid_q(rxValid_q), .rxData_q(rxData_q),
      .rxCongested(rxCongested), .pauseReq_q(pauseReq_q), .lineJam_q(lineJam_q));
   link_peer_model peer (
      .clk(clk), .peerOn(peerOn), .peerAneg(peerAneg), .peerAbility(peerAbility),
      .peerSpeed(peerSpeed), .peerCrossed(peerCrossed), .sendReq(sendReq), .anEnable_q(anEnable_q),
      .pauseReq_q(pauseReq_q), .lineJam_q(lineJam_q), .partnerPageValid(partnerPageValid),
      .partnerAbility(partnerAbility), .lineSignalValid(lineSignalValid),
      .lineSpeedDetect(lineSpeedDetect), .cableCrossed(cableCrossed), .lineRxDv(lineRxDv),
      .lineRxData(lineRxData));
   always #5 clk = ~clk;
   task cmp(input [31:0] got, input [31:0] exp);
   begin
      checked = checked + 1;
      if (got !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task wr(input [7:0] a, input [31:0] d);
   begin
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   end
   endtask
   // read data stand only in the cycle after the strobe, so look there
   task rd(input [7:0] a, input [31:0] exp);
   begin
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      cmp(regRdData_q, exp);
   end
   endtask
   task wait_link(input e);
      integer n;
   begin
      n = 0;
      while (linkUp_q !== e && n < 300)
      begin
         @(posedge clk);
         #1;
         n = n + 1;
      end
      cmp(linkUp_q, e);
   end
   endtask
   task restart;
   begin
      wait_link(1'b0);
      wait_link(1'b1);
   end
   endtask
   task t_reset;
   begin
      rd(`REG_CTRL, 32'h1);
      cmp(advertise_q, `AB_ALL);
      rd(8'h10, 32'h0);
      $display("test reset done");
   end
   endtask
   task t_neg;
   begin
      @(posedge clk);
      peerOn <= 1'b1;
      wait_link(1'b1);
      cmp({speed_q, fullDuplex_q, crossover_q}, {`SPD_100, 2'b11});
      rd(`REG_STATUS, 32'h13b);
      @(posedge clk);
      sendReq <= 1'b1;
      rxCongested <= 1'b1;
      // back to back bytes while the peer sends too
      for (i = 0; i < 4; i = i + 1)
      begin
         @(posedge clk);
         txValid <= 1'b1;
         txData <= 8'ha0 + i;
         #1;
         if (i > 0)
            cmp({lineTxEn_q, lineTxData_q, rxValid_q}, {1'b1, 8'h9f + i, 1'b1});
      end
      @(posedge clk);
      txValid <= 1'b0;
      cmp(pauseReq_q, 1'b0);
      wr(`REG_CTRL, 32'h11);
      restart;
      repeat (2) @(posedge clk);
      #1;
      cmp({pauseReq_q, lineJam_q}, 2'b10);
      @(posedge clk);
      rxCongested <= 1'b0;
      sendReq <= 1'b0;
      $display("test negotiate done");
   end
   endtask
   // frozen state must ignore both strobes and hold every output
   task t_freeze;
   begin
      @(posedge clk);
      ce <= 1'b0;
      wr(`REG_CTRL, 32'h0);
      rd(`REG_CTRL, 32'h0);
      cmp({linkUp_q, txReady_q}, 2'b11);
      @(posedge clk);
      ce <= 1'b1;
      rd(`REG_CTRL, 32'h11);
      $display("test clock enable done");
   end
   endtask
   task t_silent;
   begin
      @(posedge clk);
      peerOn <= 1'b0;
      peerAneg <= 1'b0;
      peerSpeed <= `SPD_10;
      wait_link(1'b0);
      peerOn <= 1'b1;
      wait_link(1'b1);
      cmp({speed_q, fullDuplex_q}, {`SPD_10, 1'b0});
      rd(`REG_STATUS, 32'h111);
      sendReq <= 1'b1;
      repeat (3) @(posedge clk);
      txValid <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      cmp({txReady_q, lineTxEn_q}, 2'b00);
      @(posedge clk);
      rxCongested <= 1'b1;
      seen = 1'b0;
      repeat (6)
      begin
         @(posedge clk);
         #1;
         if (lineJam_q === 1'b1)
            seen = 1'b1;
      end
      cmp({seen, pauseReq_q}, 2'b10);
      @(posedge clk);
      rxCongested <= 1'b0;
      sendReq <= 1'b0;
      txValid <= 1'b0;
      $display("test silent peer done");
   end
   endtask
   task t_forced;
   begin
      peerSpeed <= `SPD_100;
      wr(`REG_CTRL, 32'h9);
      restart;
      cmp({anEnable_q, advertise_q, crossover_q}, 32'h0);
      cmp({speed_q, fullDuplex_q}, {`SPD_100, 1'b0});
      wr(`REG_CTRL, 32'hf);
      rd(`REG_CTRL, 32'h9);
      for (i = 0; i < 6; i = i + 1)
      begin
         wr(`REG_CTRL, {23'h0, i, 1'b1});
         rd(`REG_CTRL, {23'h0, i, 1'b1});
      end
      repeat (40) @(posedge clk);
      #1;
      cmp({anEnable_q, advertise_q, linkUp_q}, 7'h60);
      wr(`REG_CTRL, 32'h3);
      repeat (40) @(posedge clk);
      #1;
      cmp(linkUp_q, 1'b0);
      $display("test forced done");
   end
   endtask
   task t_loop;
   begin
      peerAneg <= 1'b1;
      peerAbility <= `AB_ALL;
      wr(`REG_CTRL, 32'h21);
      wait_link(1'b1);
      cmp({speed_q, fullDuplex_q}, {`SPD_1000, 1'b1});
      @(posedge clk);
      txValid <= 1'b1;
      txData <= 8'h5a;
      @(posedge clk);
      txValid <= 1'b0;
      #1;
      cmp({rxValid_q, rxData_q, lineTxEn_q}, {1'b1, 8'h5a, 1'b0});
      $display("test loopback done");
   end
   endtask
   task t_admin;
   begin
      wr(`REG_CTRL, 32'h0);
      wait_link(1'b0);
      @(posedge clk);
      txValid <= 1'b1;
      sendReq <= 1'b1;
      wr(`REG_RANGE, 32'h52);
      repeat (30) @(posedge clk);
      #1;
      cmp({linkUp_q, txReady_q, rxValid_q, lineTxEn_q}, 4'h0);
      @(posedge clk);
      txValid <= 1'b0;
      sendReq <= 1'b0;
      wr(`REG_RANGE, 32'h30);
      rd(`REG_CTRL, 32'h1);
      wait_link(1'b1);
      wr(`REG_RANGE, 32'h111);
      rd(`REG_CTRL, 32'h0);
      wait_link(1'b0);
      $display("test admin done");
   end
   endtask
   task report_and_stop;
   begin
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask
   // the whole run is a few hundred cycles, so this only trips on a hang
   initial
   begin
      #200000;
      n_mismatch = n_mismatch + 1;
      report_and_stop;
   end
   initial
   begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      t_reset;
      t_neg;
      t_freeze;
      t_silent;
      t_forced;
      t_loop;
      t_admin;
      report_and_stop;
   end
endmodule
